// ### logic/rsmon_pkg.sv
package rsmon_pkg;

    // ---------------------------------------------------------------
    // reset values and field positions
    // ---------------------------------------------------------------
    localparam logic [7:0] PORT_LATCH_RST = 8'hff;
    localparam logic [15:0] START_ADDR = 16'h0000;
    localparam logic [7:0] CAUSE_RST = 8'h00;
    localparam int CAUSE_POR_BIT = 1;
    localparam int CAUSE_SW_BIT = 4;
    localparam int CAUSE_FERR_BIT = 6;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int SOFT_RST_CYCLES = 4;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        RSMON_ST_PIN = 2'b00,
        RSMON_ST_SOFT = 2'b01,
        RSMON_ST_RUN = 2'b10
    } rsmon_state_t;

    typedef struct packed {
        logic below_rst;
        logic below_warn;
    } rsmon_supply_t;

    typedef struct packed {
        logic en_wr;
        logic en;
        logic sel_wr;
        logic sel;
    } rsmon_mon_wr_t;

    typedef struct packed {
        logic halt;
        logic pc_clear;
        logic wdt_en;
        logic clk_int_sel;
    } rsmon_core_t;

endpackage : rsmon_pkg

// ### logic/rsmon_rst_sync.sv
`timescale 1ns/1ps
module rsmon_rst_sync (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // request and released reset
    input wire logic hold_req,
    output logic core_rst_n
);
    import rsmon_pkg::*;

    logic stage_r;

    // assertion is immediate, release walks through two flops so every
    // register in the core leaves reset on the same edge
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stage_r <= 1'b0;
            core_rst_n <= 1'b0;
        end else if (hold_req) begin
            stage_r <= 1'b0;
            core_rst_n <= 1'b0;
        end else begin
            stage_r <= 1'b1;
            core_rst_n <= stage_r;
        end
    end

endmodule : rsmon_rst_sync

// ### logic/rsmon_mon_cfg.sv
`timescale 1ns/1ps
module rsmon_mon_cfg (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // control
    input wire logic pin_reset,
    input wire logic sleep_mode,
    input wire rsmon_pkg::rsmon_mon_wr_t mon_wr,
    // state
    output logic mon_en_r,
    output logic mon_sel_r,
    output logic mon_active_r
);
    import rsmon_pkg::*;

    // only power-on and power-fail resets force these; soft resets keep them
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mon_en_r <= 1'b1;
            mon_sel_r <= 1'b1;
        end else if (pin_reset) begin
            mon_en_r <= 1'b1;
            mon_sel_r <= 1'b1;
        end else begin
            if (mon_wr.en_wr) begin
                mon_en_r <= mon_wr.en;
            end
            if (mon_wr.sel_wr) begin
                mon_sel_r <= mon_wr.sel;
            end
        end
    end

    // sleep masks the trip without touching the programmed bits,
    // so waking restores them for free
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mon_active_r <= 1'b0;
        end else begin
            mon_active_r <= mon_en_r & mon_sel_r & ~sleep_mode;
        end
    end

endmodule : rsmon_mon_cfg

// ### logic/rsmon_top.sv
// Operation
// - reset halts core, inits registers, disables interrupts
// - data memory untouched; stack pointer still reinitialised
// - port latches ones, open-drain, low drive, pullups
// - pin driven low during monitor and power-on resets
// - exit clears pc, enables watchdog, internal clock
// - power-on holds reset until supply above threshold
// - power-on flag set on exit; soft resets clear it
// - monitor enabled and selected after pin resets
// - enabled and selected monitor trips reset below threshold
// - power-fail reset sets flag, memory invalid
// - soft resets keep monitor enable and selection
// - sleep disables power-fail reset generation
// - wake restores programmed monitor enable and selection
// - supply-good clears below warning; optional interrupt
// - flash write without monitor causes error reset
`timescale 1ns/1ps
module rsmon_top #(
    parameter int SOFT_CYCLES = rsmon_pkg::SOFT_RST_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // supply comparators and power mode
    input wire rsmon_pkg::rsmon_supply_t supply,
    input wire logic sleep_mode,
    // software controls
    input wire rsmon_pkg::rsmon_mon_wr_t mon_wr,
    input wire logic soft_reset_req,
    input wire logic flash_prog_req,
    input wire logic wdt_disable,
    input wire logic warn_irq_en,
    // reset pin, open drain
    output logic rst_pin_o,
    output logic rst_pin_oe,
    // core side
    output logic core_rst_n,
    output rsmon_pkg::rsmon_core_t core_ctl,
    output logic [15:0] start_addr,
    output logic ram_invalid,
    // port defaults
    output logic [7:0] port_latch,
    output logic port_open_drain,
    output logic port_low_drive,
    output logic port_pullup_en,
    // status
    output logic [7:0] reset_cause_reg,
    output logic mon_en,
    output logic mon_sel,
    output logic supply_good_status,
    output logic warn_irq
);
    import rsmon_pkg::*;

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    localparam logic [7:0] SOFT_LAST = 8'(SOFT_CYCLES - 1);

    rsmon_state_t state_r;
    rsmon_state_t state_nxt;
    logic [7:0] soft_cnt_r;
    logic mon_active;
    logic pf_trip;
    logic flash_err;
    logic leaving;
    logic in_reset_nxt;

    // ---------------------------------------------------------------
    // supply monitor configuration
    // ---------------------------------------------------------------
    // monitor state kept apart
    rsmon_mon_cfg u_mon_cfg (
        .mclk(mclk),
        .reset_n(reset_n),
        .pin_reset(state_r == RSMON_ST_PIN),
        .sleep_mode(sleep_mode),
        .mon_wr(mon_wr),
        .mon_en_r(mon_en),
        .mon_sel_r(mon_sel),
        .mon_active_r(mon_active)
    );

    // trip only while active; active drops one cycle after sleep starts
    assign pf_trip = mon_active & supply.below_rst;
    // flash op with monitor off resets
    assign flash_err = flash_prog_req & ~(mon_en & mon_sel);

    // ---------------------------------------------------------------
    // reset sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RSMON_ST_PIN: begin
                if (!supply.below_rst) begin
                    state_nxt = RSMON_ST_RUN;
                end
            end
            RSMON_ST_SOFT: begin
                if (pf_trip) begin
                    state_nxt = RSMON_ST_PIN;
                end else if (soft_cnt_r == SOFT_LAST) begin
                    state_nxt = RSMON_ST_RUN;
                end
            end
            RSMON_ST_RUN: begin
                if (pf_trip) begin
                    state_nxt = RSMON_ST_PIN;
                end else if (soft_reset_req || flash_err) begin
                    state_nxt = RSMON_ST_SOFT;
                end
            end
            default: begin
                state_nxt = RSMON_ST_PIN;
            end
        endcase
    end

    assign leaving = (state_r != RSMON_ST_RUN) && (state_nxt == RSMON_ST_RUN);
    assign in_reset_nxt = (state_nxt != RSMON_ST_RUN);

    // power-on is the root: the async reset drops straight into pin reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= RSMON_ST_PIN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            soft_cnt_r <= 8'h00;
        end else if (state_r == RSMON_ST_SOFT) begin
            soft_cnt_r <= soft_cnt_r + 8'h01;
        end else begin
            soft_cnt_r <= 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // reset pin
    // ---------------------------------------------------------------
    // pull low only for pin resets
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_pin_o <= 1'b0;
            rst_pin_oe <= 1'b1;
        end else begin
            rst_pin_o <= 1'b0;
            rst_pin_oe <= (state_nxt == RSMON_ST_PIN);
        end
    end

    // ---------------------------------------------------------------
    // core control
    // ---------------------------------------------------------------
    // synchronised release
    rsmon_rst_sync u_rst_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .hold_req(in_reset_nxt),
        .core_rst_n(core_rst_n)
    );

    // halt covers register init, stack pointer, irqs, timers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            core_ctl <= '{halt: 1'b1, pc_clear: 1'b0, wdt_en: 1'b0, clk_int_sel: 1'b0};
            start_addr <= START_ADDR;
        end else begin
            core_ctl.halt <= in_reset_nxt;
            core_ctl.pc_clear <= leaving;
            core_ctl.clk_int_sel <= leaving;
            start_addr <= START_ADDR;
            if (leaving) begin
                core_ctl.wdt_en <= 1'b1;
            end else if (wdt_disable && !core_ctl.halt) begin
                core_ctl.wdt_en <= 1'b0;
            end
        end
    end

    // port defaults reloaded while in reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            port_latch <= PORT_LATCH_RST;
            port_open_drain <= 1'b1;
            port_low_drive <= 1'b1;
            port_pullup_en <= 1'b1;
        end else begin
            port_pullup_en <= 1'b1;
            if (in_reset_nxt) begin
                port_latch <= PORT_LATCH_RST;
                port_open_drain <= 1'b1;
                port_low_drive <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // reset cause and memory validity
    // ---------------------------------------------------------------
    // flag on pin-reset exit
    // soft resets mark memory valid
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reset_cause_reg <= CAUSE_RST;
            ram_invalid <= 1'b1;
        end else if (state_r == RSMON_ST_PIN && leaving) begin
            reset_cause_reg <= CAUSE_RST;
            reset_cause_reg[CAUSE_POR_BIT] <= 1'b1;
            ram_invalid <= 1'b1;
        end else if (state_r == RSMON_ST_RUN && state_nxt == RSMON_ST_SOFT) begin
            reset_cause_reg <= CAUSE_RST;
            reset_cause_reg[CAUSE_SW_BIT] <= soft_reset_req;
            reset_cause_reg[CAUSE_FERR_BIT] <= ~soft_reset_req;
            ram_invalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // early warning
    // ---------------------------------------------------------------
    // status and falling-edge request
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            supply_good_status <= 1'b0;
            warn_irq <= 1'b0;
        end else begin
            supply_good_status <= ~supply.below_warn;
            warn_irq <= warn_irq_en & supply_good_status & supply.below_warn;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_pin_low_hold: assert property (
        (state_nxt == RSMON_ST_PIN) |=> (rst_pin_oe && !rst_pin_o))
        else $error("reset pin not driven low in pin reset");
    chk_pf_enter: assert property (
        (state_r == RSMON_ST_RUN && pf_trip) |=> (state_r == RSMON_ST_PIN && rst_pin_oe))
        else $error("supply trip did not enter pin reset");
    chk_por_wait: assert property (
        (state_r == RSMON_ST_PIN && supply.below_rst) |=> (state_r == RSMON_ST_PIN))
        else $error("released below reset threshold");
    chk_flag_set: assert property (
        (state_r == RSMON_ST_PIN && !supply.below_rst)
        |=> (reset_cause_reg[CAUSE_POR_BIT] && ram_invalid))
        else $error("power-on flag not set on exit");
    chk_flag_clear: assert property (
        (state_r == RSMON_ST_RUN && !pf_trip && soft_reset_req)
        |=> (!reset_cause_reg[CAUSE_POR_BIT] && state_r == RSMON_ST_SOFT))
        else $error("soft reset kept power-on flag");
    chk_exit_ctl: assert property (
        leaving |=> (core_ctl.pc_clear && core_ctl.wdt_en && core_ctl.clk_int_sel
                     && start_addr == START_ADDR))
        else $error("exit actions missing");
    chk_core_sync: assert property (
        leaving |=> !core_rst_n ##1 core_rst_n)
        else $error("core release not two cycles after exit");
    chk_sleep_mask: assert property (
        (sleep_mode && $past(sleep_mode)) |-> !pf_trip)
        else $error("power-fail trip while asleep");
    chk_mon_forced: assert property (
        (state_r == RSMON_ST_PIN) |=> (mon_en && mon_sel))
        else $error("monitor not enabled after pin reset");
    chk_flash_err: assert property (
        (state_r == RSMON_ST_RUN && !pf_trip && !soft_reset_req && flash_err)
        |=> (state_r == RSMON_ST_SOFT && reset_cause_reg[CAUSE_FERR_BIT]))
        else $error("flash error reset missing");
    chk_port_init: assert property (
        core_ctl.halt |-> (port_latch == PORT_LATCH_RST && port_open_drain && port_low_drive))
        else $error("port defaults not held in reset");
    chk_warn_bit: assert property (
        supply.below_warn |=> !supply_good_status)
        else $error("supply-good not cleared below warning");

    cov_por_exit: cover property (state_r == RSMON_ST_PIN ##1 state_r == RSMON_ST_RUN);
    cov_soft: cover property (state_r == RSMON_ST_SOFT ##1 state_r == RSMON_ST_RUN);
    cov_pf: cover property (state_r == RSMON_ST_RUN && pf_trip);
    cov_warn: cover property (warn_irq);

endmodule : rsmon_top

// ### verif/rsmon_supply_model.sv
`timescale 1ns/1ps
module rsmon_supply_model (
    // commands from the bench
    input wire logic drop_rst,
    input wire logic drop_warn,
    // reset pin as driven by the device
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe,
    // comparator outputs and pin level
    output rsmon_pkg::rsmon_supply_t supply,
    output logic rst_pin_level
);
    import rsmon_pkg::*;

    // ---------------------------------------------------------------
    // comparators
    // ---------------------------------------------------------------
    // supply below reset threshold
    // the warning threshold sits above the reset one, so a deep drop trips both
    assign supply.below_rst = drop_rst;
    assign supply.below_warn = drop_warn | drop_rst;

    // ---------------------------------------------------------------
    // reset pin
    // ---------------------------------------------------------------
    // open drain with external pullup: released pin reads high
    assign rst_pin_level = rst_pin_oe ? rst_pin_o : 1'b1;

endmodule : rsmon_supply_model

// ### verif/rsmon_top_tb_top.sv
`timescale 1ns/1ps
module rsmon_top_tb_top;
    import rsmon_pkg::*;

`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end

    localparam int SC = 4;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic drop_rst = 1'b1;
    logic drop_warn = 1'b1;
    logic sleep_mode = 1'b0;
    rsmon_mon_wr_t mon_wr = '0;
    logic soft_reset_req = 1'b0;
    logic flash_prog_req = 1'b0;
    logic wdt_disable = 1'b0;
    logic warn_irq_en = 1'b0;
    rsmon_supply_t supply;
    rsmon_core_t core_ctl;
    logic rst_pin_o, rst_pin_oe, core_rst_n, ram_invalid, rst_pin_level;
    logic port_open_drain, port_low_drive, port_pullup_en;
    logic mon_en, mon_sel, supply_good_status, warn_irq;
    logic [15:0] start_addr;
    logic [7:0] port_latch, reset_cause_reg;
    int miscompares = 0;
    int checks_done = 0;
    int irq_cnt = 0;

    always #2.5 mclk = ~mclk;

    always @(posedge mclk) begin
        if (warn_irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
    end

    rsmon_top #(.SOFT_CYCLES(SC)) i_rsmon_top (.mclk(mclk), .reset_n(reset_n),
        .supply(supply), .sleep_mode(sleep_mode), .mon_wr(mon_wr),
        .soft_reset_req(soft_reset_req), .flash_prog_req(flash_prog_req),
        .wdt_disable(wdt_disable), .warn_irq_en(warn_irq_en), .rst_pin_o(rst_pin_o),
        .rst_pin_oe(rst_pin_oe), .core_rst_n(core_rst_n), .core_ctl(core_ctl),
        .start_addr(start_addr), .ram_invalid(ram_invalid), .port_latch(port_latch),
        .port_open_drain(port_open_drain), .port_low_drive(port_low_drive),
        .port_pullup_en(port_pullup_en), .reset_cause_reg(reset_cause_reg),
        .mon_en(mon_en), .mon_sel(mon_sel), .supply_good_status(supply_good_status),
        .warn_irq(warn_irq));

    rsmon_supply_model i_rsmon_supply_model (.drop_rst(drop_rst), .drop_warn(drop_warn),
        .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .supply(supply),
        .rst_pin_level(rst_pin_level));

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // called just after the exit edge of any reset, while the pulses stand
    task automatic chk_exit(input logic [7:0] cause);
        `CHK("exit pulses", 5'b00111, {rst_pin_oe, core_ctl}) // exit actions
        `CHK("cause", cause, reset_cause_reg) // cause flags
        `CHK("start", START_ADDR, start_addr) // start address
        step(1);
        `CHK("core_rst_n", 2'b10, {core_rst_n, core_ctl.pc_clear}) // synced release
    endtask : chk_exit

    // called just after the edge that took a non-pin reset request
    task automatic soft_run(input logic [7:0] cause);
        step(1);
        `CHK("soft entry", 4'b0100, {rst_pin_oe, core_ctl.halt, core_rst_n, ram_invalid})
        `CHK("soft cause", cause, reset_cause_reg) // flag cleared
        step(SC - 2);
        `CHK("soft held", 1'b1, core_ctl.halt) // still halted
        step(1);
        chk_exit(cause); // exit actions
    endtask : soft_run

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        step(4);
        `CHK("latch", PORT_LATCH_RST, port_latch) // latch ones
        `CHK("port mode", 3'b111, {port_open_drain, port_low_drive, port_pullup_en})
        `CHK("pin", 1'b0, rst_pin_level) // pin low
        `CHK("halt", 2'b10, {core_ctl.halt, core_rst_n}) // halted
        `CHK("mon", 2'b11, {mon_en, mon_sel}) // monitor on
        reset_n = 1'b1;
        step(3);
        // supply still low after the root reset lets go
        `CHK("por hold", 2'b00, {rst_pin_level, core_rst_n}) // held
        drop_rst = 1'b0;
        drop_warn = 1'b0;
        step(1);
        chk_exit(8'h02); // power-on flag
        `CHK("ram", 2'b11, {ram_invalid, port_pullup_en}) // ram invalid
        $display("test power_on done");
        warn_irq_en = 1'b1;
        drop_warn = 1'b1;
        step(1);
        `CHK("supply_good", 1'b0, supply_good_status) // status clears
        step(3);
        `CHK("irq", 1, irq_cnt) // interrupt raised
        warn_irq_en = 1'b0;
        drop_warn = 1'b0;
        step(2);
        `CHK("supply_good", 1'b1, supply_good_status) // status back
        drop_warn = 1'b1;
        step(4);
        `CHK("irq masked", 1, irq_cnt) // interrupt masked
        drop_warn = 1'b0;
        $display("test warning done");
        wdt_disable = 1'b1;
        step(1);
        wdt_disable = 1'b0;
        step(1);
        `CHK("wdt off", 1'b0, core_ctl.wdt_en) // watchdog off
        mon_wr = '{1'b1, 1'b0, 1'b1, 1'b0};
        step(1);
        mon_wr = '0;
        step(1);
        `CHK("mon off", 2'b00, {mon_en, mon_sel}) // written
        soft_reset_req = 1'b1;
        step(1);
        soft_reset_req = 1'b0;
        soft_run(8'h10); // pin untouched
        `CHK("mon kept", 2'b00, {mon_en, mon_sel}) // kept
        drop_rst = 1'b1;
        step(4);
        `CHK("no trip", 2'b01, {rst_pin_oe, core_rst_n}) // monitor off
        drop_rst = 1'b0;
        step(1);
        flash_prog_req = 1'b1;
        step(1);
        flash_prog_req = 1'b0;
        soft_run(8'h40); // flash error reset
        mon_wr = '{1'b1, 1'b1, 1'b1, 1'b1};
        step(1);
        mon_wr = '0;
        flash_prog_req = 1'b1;
        step(1);
        flash_prog_req = 1'b0;
        step(4);
        `CHK("flash ok", 9'h140, {core_rst_n, reset_cause_reg}) // no reset
        $display("test soft_flash done");
        sleep_mode = 1'b1;
        step(2);
        drop_rst = 1'b1;
        step(4);
        `CHK("sleep", 2'b01, {rst_pin_oe, core_rst_n}) // no trip asleep
        drop_rst = 1'b0;
        step(1);
        sleep_mode = 1'b0;
        step(2);
        `CHK("wake mon", 2'b11, {mon_en, mon_sel}) // restored
        drop_rst = 1'b1;
        step(2);
        `CHK("pf entry", 3'b010, {rst_pin_level, core_ctl.halt, core_rst_n}) // trip
        step(3);
        `CHK("pf held", 1'b1, rst_pin_oe) // pin held
        drop_rst = 1'b0;
        step(1);
        chk_exit(8'h02); // flag reads one
        `CHK("pf state", 3'b111, {ram_invalid, mon_en, mon_sel}) // monitor on
        $display("test power_fail done");
        test_done();
    end

    // the whole sequence needs about 60 cycles
    initial begin
        repeat (2000) @(posedge mclk);
        miscompares++;
        test_done();
    end

endmodule : rsmon_top_tb_top
